// file: design/lhb_host_bus_port.sv
`timescale 1ns/100ps
module lhb_host_bus_port #(
    parameter int DB_W = lhb_pkg::DB_W,
    parameter int IDX_W = lhb_pkg::IDX_W
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic pixel_clock_in,
    input wire logic [3:0] interface_mode_pin_in,
    input wire logic chip_sel_n_in,
    input wire logic index_or_control_sel_in,
    input wire logic wr_strobe_n_in,
    input wire logic rd_strobe_n_in,
    input wire logic [17:0] parallel_data_bus_in,
    output logic [17:0] parallel_data_bus_out,
    output logic parallel_data_bus_oe_out,
    input wire logic serial_clock_in,
    input wire logic serial_in_line_in,
    output logic serial_out_line_out,
    input wire logic data_valid_in,
    input wire logic rgb_mode_in,
    input wire logic [1:0] rgb_width_in,
    input wire logic pixel_edge_polarity_in,
    input wire logic valid_strobe_polarity_in,
    input wire logic [17:0] status_in,
    input wire logic [17:0] ctrl_rd_data_in,
    output logic [IDX_W-1:0] index_out,
    output logic ctrl_wr_valid_out,
    input wire logic ctrl_wr_ready_in,
    output logic [17:0] ctrl_wr_data_out,
    output logic [IDX_W-1:0] ctrl_wr_index_out,
    output logic ctrl_wr_overrun_out,
    output logic [17:0] pixel_data_out,
    output logic pixel_valid_out,
    output logic mode_invalid_out
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Mode pin decode; unlisted codes are invalid
    function automatic lhb_pkg::lhb_mode_type mode_decode(input logic [3:0] code);
        unique case (code)
            lhb_pkg::IM_P8: mode_decode = lhb_pkg::MODE_P8;
            lhb_pkg::IM_P9: mode_decode = lhb_pkg::MODE_P9;
            lhb_pkg::IM_P16: mode_decode = lhb_pkg::MODE_P16;
            lhb_pkg::IM_P18: mode_decode = lhb_pkg::MODE_P18;
            lhb_pkg::IM_S3: mode_decode = lhb_pkg::MODE_S3;
            lhb_pkg::IM_S4: mode_decode = lhb_pkg::MODE_S4;
            default: mode_decode = lhb_pkg::MODE_BAD;
        endcase
    endfunction
    // Gather the lines in use into a right-aligned word
    function automatic logic [17:0] par_unpack(input lhb_pkg::lhb_mode_type m,
                                               input logic [17:0] db);
        unique case (m)
            lhb_pkg::MODE_P8: par_unpack = {10'h000, db[17:10]};
            lhb_pkg::MODE_P9: par_unpack = {9'h000, db[17:9]};
            lhb_pkg::MODE_P16: par_unpack = {2'h0, db[17:10], db[8:1]};
            lhb_pkg::MODE_P18: par_unpack = db;
            default: par_unpack = 18'h00000;
        endcase
    endfunction
    // Spread a word onto the lines in use, others zero
    function automatic logic [17:0] par_pack(input lhb_pkg::lhb_mode_type m,
                                             input logic [17:0] w);
        unique case (m)
            lhb_pkg::MODE_P8: par_pack = {w[7:0], 10'h000};
            lhb_pkg::MODE_P9: par_pack = {w[8:0], 9'h000};
            lhb_pkg::MODE_P16: par_pack = {w[15:8], 1'b0, w[7:0], 1'b0};
            lhb_pkg::MODE_P18: par_pack = w;
            default: par_pack = 18'h00000;
        endcase
    endfunction
    // Pixel word from the lines of the pixel width
    function automatic logic [17:0] rgb_unpack(input logic [1:0] wsel, input logic [17:0] db);
        unique case (wsel)
            lhb_pkg::RGB_W6: rgb_unpack = {12'h000, db[17:12]};
            lhb_pkg::RGB_W16: rgb_unpack = {2'h0, db[17:13], db[11:1]};
            default: rgb_unpack = db;
        endcase
    endfunction

    // ----------------------------------------
    // Pin synchroniser (mclk domain)
    // ----------------------------------------
    logic [lhb_pkg::SYNC_W-1:0] sync1_reg; // First stage, read only by second
    logic [lhb_pkg::SYNC_W-1:0] sync2_reg; // Second stage, safe to use
    // Data shares the strobe delay so they stay aligned
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1_reg <= lhb_pkg::SYNC_RST;
            sync2_reg <= lhb_pkg::SYNC_RST;
        end else begin
            sync1_reg <= {interface_mode_pin_in, serial_clock_in, serial_in_line_in,
                index_or_control_sel_in, parallel_data_bus_in, chip_sel_n_in,
                wr_strobe_n_in, rd_strobe_n_in};
            sync2_reg <= sync1_reg;
        end
    end
    wire [3:0] mode_pins_s = sync2_reg[27:24];
    wire sclk_s = sync2_reg[23];
    wire sdi_s = sync2_reg[22];
    wire rs_s = sync2_reg[21];
    wire [17:0] db_s = sync2_reg[20:3];
    wire cs_n_s = sync2_reg[2];
    wire wr_n_s = sync2_reg[1];
    wire rd_n_s = sync2_reg[0];

    // ----------------------------------------
    // Mode and edge decode
    // ----------------------------------------
    logic [2:0] prev_reg; // Last serial clock, write strobe and chip select
    wire lhb_pkg::lhb_mode_type mode = mode_decode(mode_pins_s);
    wire ser_mode = (mode == lhb_pkg::MODE_S3) || (mode == lhb_pkg::MODE_S4);
    wire par_mode = !ser_mode && (mode != lhb_pkg::MODE_BAD);
    wire selected = !cs_n_s;
    wire sclk_rise = sclk_s && !prev_reg[2];
    wire wr_rise = wr_n_s && !prev_reg[1];
    wire cs_fall = prev_reg[0] && !cs_n_s;
    // Write taken at the strobe's rising edge, while selected
    wire par_wr_evt = par_mode && selected && wr_rise;
    wire rd_active = par_mode && selected && !rd_n_s;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            prev_reg <= 3'h3;
        end else begin
            prev_reg <= {sclk_s, wr_n_s, cs_n_s};
        end
    end

    // ----------------------------------------
    // Serial receive and transmit
    // ----------------------------------------
    logic [3:0] ser_cnt_reg; // Bits received in this word
    logic [7:0] ser_shift_reg; // Bits received so far
    logic [7:0] ser_tx_reg; // Status bits still to send
    logic serial_out_reg;
    wire [3:0] ser_len = (mode == lhb_pkg::MODE_S3) ? lhb_pkg::S3_BITS : lhb_pkg::S4_BITS;
    wire ser_take = ser_mode && selected && sclk_rise;
    wire [3:0] ser_cnt_inc = ser_cnt_reg + 4'h1;
    wire ser_wr_evt = ser_take && (ser_cnt_inc == ser_len);
    wire [8:0] ser_word = {ser_shift_reg, sdi_s};
    // 3-wire carries the select as first bit; 4-wire uses the select pin
    wire ser_rs = (mode == lhb_pkg::MODE_S3) ? ser_word[8] : rs_s;
    // Chip select high drops a part word
    always_ff @(posedge mclk_in) begin
        if (srst_in || cs_n_s || !ser_mode) begin
            ser_cnt_reg <= 4'h0;
            ser_shift_reg <= 8'h00;
        end else if (ser_take) begin
            ser_cnt_reg <= ser_wr_evt ? 4'h0 : ser_cnt_inc;
            ser_shift_reg <= ser_word[7:0];
        end
    end
    // Status is loaded at select and shifted out MSB first
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ser_tx_reg <= 8'h00;
            serial_out_reg <= 1'b0;
        end else if (cs_fall) begin
            ser_tx_reg <= status_in[7:0];
        end else if (ser_take) begin
            serial_out_reg <= ser_tx_reg[7];
            ser_tx_reg <= {ser_tx_reg[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Write routing: index or control
    // ----------------------------------------
    logic [IDX_W-1:0] index_reg;
    logic pend_v_reg; // Control write awaiting buffer room
    logic [17:0] pend_data_reg;
    logic [IDX_W-1:0] pend_idx_reg;
    logic overrun_reg;
    logic buf_full;
    wire wr_evt = par_wr_evt || ser_wr_evt;
    wire wr_rs = par_wr_evt ? rs_s : ser_rs;
    wire [17:0] wr_word = par_wr_evt ? par_unpack(mode, db_s) : {10'h000, ser_word[7:0]};
    wire idx_evt = wr_evt && !wr_rs;
    wire ctl_evt = wr_evt && wr_rs;
    wire push = pend_v_reg && !buf_full; // Full buffer stalls the pending word
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            index_reg <= lhb_pkg::IDX_RST;
        end else if (idx_evt) begin
            index_reg <= wr_word[IDX_W-1:0];
        end
    end
    // A new control write over a stalled one replaces it and flags the loss
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pend_v_reg <= 1'b0;
            pend_data_reg <= lhb_pkg::DB_RST;
            pend_idx_reg <= lhb_pkg::IDX_RST;
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= ctl_evt && pend_v_reg && !push;
            if (ctl_evt) begin
                pend_v_reg <= 1'b1;
                pend_data_reg <= wr_word;
                pend_idx_reg <= index_reg;
            end else if (push) begin
                pend_v_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Two-entry buffer toward the user
    // ----------------------------------------
    logic out_v_reg;
    logic [17:0] out_data_reg;
    logic [IDX_W-1:0] out_idx_reg;
    logic spare_v_reg;
    logic [17:0] spare_data_reg;
    logic [IDX_W-1:0] spare_idx_reg;
    wire pop = out_v_reg && ctrl_wr_ready_in;
    assign buf_full = out_v_reg && spare_v_reg;
    // Head drives outputs; spare catches a word in a stall
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            out_v_reg <= 1'b0;
            spare_v_reg <= 1'b0;
            out_data_reg <= lhb_pkg::DB_RST;
            out_idx_reg <= lhb_pkg::IDX_RST;
            spare_data_reg <= lhb_pkg::DB_RST;
            spare_idx_reg <= lhb_pkg::IDX_RST;
        end else if (pop && spare_v_reg) begin
            out_data_reg <= spare_data_reg;
            out_idx_reg <= spare_idx_reg;
            spare_v_reg <= push;
            spare_data_reg <= pend_data_reg;
            spare_idx_reg <= pend_idx_reg;
        end else if (pop || !out_v_reg) begin
            out_v_reg <= push;
            out_data_reg <= pend_data_reg;
            out_idx_reg <= pend_idx_reg;
        end else if (push) begin
            spare_v_reg <= 1'b1;
            spare_data_reg <= pend_data_reg;
            spare_idx_reg <= pend_idx_reg;
        end
    end

    // ----------------------------------------
    // Parallel read drive
    // ----------------------------------------
    logic [17:0] db_out_reg;
    logic db_oe_reg;
    logic mode_bad_reg;
    wire [17:0] rd_word = rs_s ? ctrl_rd_data_in : status_in;
    // Drive only while selected and the read strobe is low
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            db_out_reg <= lhb_pkg::DB_RST;
            db_oe_reg <= 1'b0;
            mode_bad_reg <= 1'b0;
        end else begin
            db_out_reg <= rd_active ? par_pack(mode, rd_word) : lhb_pkg::DB_RST;
            db_oe_reg <= rd_active;
            mode_bad_reg <= (mode == lhb_pkg::MODE_BAD);
        end
    end

    // ----------------------------------------
    // Pixel clock domain
    // ----------------------------------------
    logic [5:0] px_s1_reg; // First stage, read only by second
    logic [5:0] px_s2_reg;
    logic [18:0] rise_reg; // Valid strobe over bus, rising edge
    logic [18:0] fall_reg; // Same at the falling edge
    logic [17:0] px_hold_reg; // Stable for a whole pixel period after a toggle
    logic px_tog_reg;
    wire px_rst = px_s2_reg[5];
    wire px_on = px_s2_reg[4];
    wire [1:0] px_width = px_s2_reg[3:2];
    wire px_dpl = px_s2_reg[1];
    wire px_epl = px_s2_reg[0];
    // Reset and configuration resynchronised to the pixel clock
    always_ff @(posedge pixel_clock_in) begin
        px_s1_reg <= {srst_in, rgb_mode_in, rgb_width_in, pixel_edge_polarity_in,
                      valid_strobe_polarity_in};
        px_s2_reg <= px_s1_reg;
    end
    // Both edges sampled; the polarity picks one
    always_ff @(posedge pixel_clock_in) begin
        rise_reg <= {data_valid_in, parallel_data_bus_in};
    end
    always_ff @(negedge pixel_clock_in) begin
        fall_reg <= {data_valid_in, parallel_data_bus_in};
    end
    wire [18:0] px_in = px_dpl ? fall_reg : rise_reg;
    wire px_good = px_on && (px_in[18] == px_epl);
    always_ff @(posedge pixel_clock_in) begin
        if (px_rst) begin
            px_hold_reg <= lhb_pkg::DB_RST;
            px_tog_reg <= 1'b0;
        end else if (px_good) begin
            px_hold_reg <= rgb_unpack(px_width, px_in[17:0]);
            px_tog_reg <= !px_tog_reg;
        end
    end

    // ----------------------------------------
    // Pixel crossing into mclk
    // ----------------------------------------
    // Toggle crossing: held word outlives the detect delay
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic [17:0] pix_data_reg;
    logic pix_valid_reg;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            pix_data_reg <= lhb_pkg::DB_RST;
            pix_valid_reg <= 1'b0;
        end else begin
            tog_s1_reg <= px_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            pix_valid_reg <= tog_s2_reg ^ tog_s3_reg;
            if (tog_s2_reg ^ tog_s3_reg) begin
                pix_data_reg <= px_hold_reg;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign parallel_data_bus_out = db_out_reg;
    assign parallel_data_bus_oe_out = db_oe_reg;
    assign serial_out_line_out = serial_out_reg;
    assign index_out = index_reg;
    assign ctrl_wr_valid_out = out_v_reg;
    assign ctrl_wr_data_out = out_data_reg;
    assign ctrl_wr_index_out = out_idx_reg;
    assign ctrl_wr_overrun_out = overrun_reg;
    assign pixel_data_out = pix_data_reg;
    assign pixel_valid_out = pix_valid_reg;
    assign mode_invalid_out = mode_bad_reg;
endmodule

// file: design/lhb_pkg.sv
package lhb_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DB_W = 18;              // Parallel bus lines
    localparam int IDX_W = 8;              // Index register width
    localparam int SYNC_W = 28;            // Pins passed through the mclk synchroniser
    // ----------------------------------------
    // Interface mode pin codes
    // ----------------------------------------
    localparam logic [3:0] IM_P16 = 4'h2;  // 16-bit parallel
    localparam logic [3:0] IM_P8 = 4'h3;   // 8-bit parallel
    localparam logic [3:0] IM_P18 = 4'hA;  // 18-bit parallel
    localparam logic [3:0] IM_P9 = 4'hB;   // 9-bit parallel
    localparam logic [3:0] IM_S3 = 4'h6;   // 3-wire 9-bit serial
    localparam logic [3:0] IM_S4 = 4'h7;   // 4-wire 8-bit serial
    // ----------------------------------------
    // External pixel widths
    // ----------------------------------------
    localparam logic [1:0] RGB_W6 = 2'h0;
    localparam logic [1:0] RGB_W16 = 2'h1;
    localparam logic [1:0] RGB_W18 = 2'h2;
    // ----------------------------------------
    // Serial frame lengths and reset values
    // ----------------------------------------
    localparam logic [3:0] S3_BITS = 4'h9;
    localparam logic [3:0] S4_BITS = 4'h8;
    localparam logic [17:0] DB_RST = 18'h00000;
    localparam logic [7:0] IDX_RST = 8'h00;
    localparam logic [SYNC_W-1:0] SYNC_RST = 28'h0000007; // Strobes and select idle high
    // Host interface selected by the mode pins
    typedef enum logic [2:0] {
        MODE_BAD, MODE_P8, MODE_P9, MODE_P16, MODE_P18, MODE_S3, MODE_S4
    } lhb_mode_type;
endpackage

// file: test/lhb_host_bus_port_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module lhb_host_bus_port_assertions #(
    parameter int IDX_W = 8
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [3:0] interface_mode_pin_in,
    input wire logic chip_sel_n_in,
    input wire logic rd_strobe_n_in,
    input wire logic [17:0] parallel_data_bus_out,
    input wire logic parallel_data_bus_oe_out,
    input wire logic [IDX_W-1:0] index_out,
    input wire logic ctrl_wr_valid_out,
    input wire logic ctrl_wr_ready_in,
    input wire logic [17:0] ctrl_wr_data_out,
    input wire logic ctrl_wr_overrun_out,
    input wire logic pixel_valid_out,
    input wire logic mode_invalid_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    // Valid codes: bit 1 set, top bits not both set
    wire [3:0] im = interface_mode_pin_in;
    wire code_ok = im[1] & ~(im[3] & im[2]);
    wire rd_req = !chip_sel_n_in && !rd_strobe_n_in;
    wire [17:0] b = parallel_data_bus_out;
    // Unused lanes of the narrow widths stay low
    wire lanes_ok = (im == lhb_pkg::IM_P8) ? b[9:0] == 10'h000 :
        (im == lhb_pkg::IM_P9) ? b[8:0] == 9'h000 :
        (im == lhb_pkg::IM_P16) ? {b[9], b[0]} == 2'h0 : 1'h1;
    a_read_cause: assert property (parallel_data_bus_oe_out |-> $past(rd_req, 3))
        else $error("bus driven unasked");
    a_idle_bus_zero: assert property (!parallel_data_bus_oe_out |-> b == 18'h00000)
        else $error("idle bus not zero");
    a_bus_lanes: assert property (parallel_data_bus_oe_out |-> lanes_ok)
        else $error("data on unused lane");
    a_stall_holds: assert property (ctrl_wr_valid_out && !ctrl_wr_ready_in |=>
        ctrl_wr_valid_out && $stable(ctrl_wr_data_out))
        else $error("stalled word changed");
    a_overrun_full: assert property (ctrl_wr_overrun_out |->
        ctrl_wr_valid_out && !$past(ctrl_wr_ready_in))
        else $error("overrun without stall");
    a_pixel_pulse: assert property (pixel_valid_out |=> !pixel_valid_out [*8])
        else $error("pixel pulse repeated");
    a_index_by_cs: assert property ($changed(index_out) |-> $past(!chip_sel_n_in, 3))
        else $error("index changed unselected");
    a_invalid_code: assert property (!code_ok [*5] |-> mode_invalid_out)
        else $error("invalid code unflagged");
    a_valid_code: assert property (code_ok [*5] |-> !mode_invalid_out)
        else $error("valid code flagged");
endmodule
bind lhb_host_bus_port lhb_host_bus_port_assertions #(.IDX_W(IDX_W)) lhb_chk_inst (
    .mclk_in(mclk_in), .srst_in(srst_in), .interface_mode_pin_in(interface_mode_pin_in),
    .chip_sel_n_in(chip_sel_n_in), .rd_strobe_n_in(rd_strobe_n_in),
    .parallel_data_bus_out(parallel_data_bus_out),
    .parallel_data_bus_oe_out(parallel_data_bus_oe_out), .index_out(index_out),
    .ctrl_wr_valid_out(ctrl_wr_valid_out), .ctrl_wr_ready_in(ctrl_wr_ready_in),
    .ctrl_wr_data_out(ctrl_wr_data_out), .ctrl_wr_overrun_out(ctrl_wr_overrun_out),
    .pixel_valid_out(pixel_valid_out), .mode_invalid_out(mode_invalid_out));

// file: test/lhb_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host controller model on the pins
// ----------------------------------------
module lhb_host_model (
    input wire logic mclk_in,
    input wire logic pixel_clock_in,
    input wire logic [17:0] db_in,
    input wire logic so_in,
    output logic cs_n_out,
    output logic sel_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic [17:0] db_out,
    output logic dv_out,
    output logic sclk_out,
    output logic sdi_out
);
    // Idle levels; serial clock stands still outside frames
    initial begin
        {cs_n_out, wr_n_out, rd_n_out, dv_out} = 4'hF;
        {sel_out, sclk_out, sdi_out} = 3'h0;
        db_out = 18'h00000;
    end
    // Waits n cycles; each level held at least 4 cycles for the synchroniser, except chip select high between back-to-back reads (1 cycle)
    task automatic gap(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // Parallel write, ended by the strobe rise
    task automatic wr(input logic cs_n, input logic sel, input logic [17:0] d);
        gap(1);
        cs_n_out = cs_n;
        sel_out = sel;
        db_out = d;
        wr_n_out = 1'h0;
        gap(4);
        wr_n_out = 1'h1;
        gap(4);
        cs_n_out = 1'h1;
        db_out = ~d; // Released lines lose their value
        gap(6);
    endtask
    // Parallel read, data taken while the strobe is still low
    task automatic rd(input logic sel, output logic [17:0] q);
        gap(1);
        cs_n_out = 1'h0;
        sel_out = sel;
        rd_n_out = 1'h0;
        gap(6);
        q = db_in;
        rd_n_out = 1'h1;
        gap(4);
        cs_n_out = 1'h1;
    endtask
    // Serial frame, MSB first; output bit taken before each fall
    task automatic ser(input int n, input logic sel, input logic [8:0] w, output logic [7:0] q);
        gap(1);
        cs_n_out = 1'h0;
        sel_out = sel;
        gap(4);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = w[i];
            gap(4);
            sclk_out = 1'h1;
            gap(4);
            if (i < 8) q[i] = so_in;
            sclk_out = 1'h0;
        end
        gap(4);
        cs_n_out = 1'h1;
        sdi_out = ~sdi_out;
        gap(6);
    endtask
    // One pixel beat, launched opposite the capture edge
    task automatic pix(input logic fall, input logic dv, input logic dv2, input logic [17:0] d);
        @(pixel_clock_in iff (pixel_clock_in == fall));
        db_out = d;
        dv_out = dv;
        @(pixel_clock_in iff (pixel_clock_in == fall));
        dv_out = dv2;
        db_out = ~d;
    endtask
endmodule

// file: test/test_lhb_host_bus_port.sv
`timescale 1ns/100ps
module test_lhb_host_bus_port;
    logic mclk = 1'h0;
    logic pclk = 1'h0;
    logic srst = 1'h1;
    logic [3:0] mode_pins = lhb_pkg::IM_P8;
    logic [3:0] pm [4] = '{lhb_pkg::IM_P8, lhb_pkg::IM_P9, lhb_pkg::IM_P16, lhb_pkg::IM_P18};
    logic [3:0] bad [8] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'h9, 4'hC, 4'hE, 4'hF};
    logic wr_ready = 1'h1;
    logic rgb_mode = 1'h0;
    logic [1:0] rgb_width;
    logic edge_pol;
    logic dv_pol;
    logic [17:0] status;
    logic [17:0] ctrl_rd;
    logic [31:0] rnd = 32'h8C62168F;
    logic [17:0] pop_data, pix_data, q, d;
    logic [7:0] pop_idx, sq, e;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    int pops = 0;
    int ovr = 0;
    int pixn = 0;
    int n0;
    wire cs_n, sel, wr_n, rd_n, dv, sclk, serial_in_line, so, oe, wv, ovf, pv, inv;
    wire [17:0] host_db, dev_db, wdata, pdata;
    wire [7:0] idx, widx;
    // The driving end wins the bus
    wire [17:0] bus = oe ? dev_db : host_db;
    // Two unrelated clocks
    always #2 mclk = ~mclk;
    always #62.5 pclk = ~pclk;
    lhb_host_bus_port lhb_host_bus_port_inst (.mclk_in(mclk), .srst_in(srst),
        .pixel_clock_in(pclk), .interface_mode_pin_in(mode_pins), .chip_sel_n_in(cs_n),
        .index_or_control_sel_in(sel), .wr_strobe_n_in(wr_n), .rd_strobe_n_in(rd_n),
        .parallel_data_bus_in(bus), .parallel_data_bus_out(dev_db),
        .parallel_data_bus_oe_out(oe), .serial_clock_in(sclk), .serial_in_line_in(serial_in_line),
        .serial_out_line_out(so), .data_valid_in(dv), .rgb_mode_in(rgb_mode),
        .rgb_width_in(rgb_width), .pixel_edge_polarity_in(edge_pol),
        .valid_strobe_polarity_in(dv_pol), .status_in(status), .ctrl_rd_data_in(ctrl_rd),
        .index_out(idx), .ctrl_wr_valid_out(wv), .ctrl_wr_ready_in(wr_ready),
        .ctrl_wr_data_out(wdata), .ctrl_wr_index_out(widx), .ctrl_wr_overrun_out(ovf),
        .pixel_data_out(pdata), .pixel_valid_out(pv), .mode_invalid_out(inv));
    lhb_host_model lhb_host_model_inst (.mclk_in(mclk), .pixel_clock_in(pclk), .db_in(bus),
        .so_in(so), .cs_n_out(cs_n), .sel_out(sel), .wr_n_out(wr_n), .rd_n_out(rd_n),
        .db_out(host_db), .dv_out(dv), .sclk_out(sclk), .sdi_out(serial_in_line));
    // Record pops, overruns and pixels; cut a hang short
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (wv === 1'h1 && wr_ready === 1'h1) begin
            pops <= pops + 1;
            pop_data <= wdata;
            pop_idx <= widx;
        end
        if (ovf === 1'h1) ovr <= ovr + 1;
        if (pv === 1'h1) begin
            pixn <= pixn + 1;
            pix_data <= pdata;
        end
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Word the core sees for a parallel width
    function automatic logic [17:0] unpack(input logic [3:0] m, input logic [17:0] v);
        case (m)
            lhb_pkg::IM_P8: return {10'h000, v[17:10]};
            lhb_pkg::IM_P9: return {9'h000, v[17:9]};
            lhb_pkg::IM_P16: return {2'h0, v[17:10], v[8:1]};
            default: return v;
        endcase
    endfunction
    // Read word on a width's lanes
    function automatic logic [17:0] pack(input logic [3:0] m, input logic [17:0] v);
        case (m)
            lhb_pkg::IM_P8: return {v[7:0], 10'h000};
            lhb_pkg::IM_P9: return {v[8:0], 9'h000};
            lhb_pkg::IM_P16: return {v[15:8], 1'h0, v[7:0], 1'h0};
            default: return v;
        endcase
    endfunction
    // Pixel word for an external width
    function automatic logic [17:0] pixw(input logic [1:0] w, input logic [17:0] v);
        case (w)
            lhb_pkg::RGB_W6: return {12'h000, v[17:12]};
            lhb_pkg::RGB_W16: return {2'h0, v[17:13], v[11:1]};
            default: return v;
        endcase
    endfunction
    task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reset spans three rising pixel edges so both domains clear
    initial begin
        repeat (100) @(negedge mclk);
        srst = 1'h0;
        foreach (pm[i]) begin
            mode_pins = pm[i];
            rnd = lfsr(rnd);
            d = rnd[17:0];
            q = unpack(pm[i], d);
            e = q[7:0];
            lhb_host_model_inst.wr(1'h0, 1'h0, d);
            chk("index", {10'h000, e}, {10'h000, idx});
            lhb_host_model_inst.wr(1'h0, 1'h1, ~d);
            chk("ctrl data", unpack(pm[i], ~d), pop_data);
            chk("ctrl index", {10'h000, e}, {10'h000, pop_idx});
            status = rnd[31:14];
            ctrl_rd = rnd[17:0] ^ 18'h2A5A5;
            lhb_host_model_inst.rd(1'h0, q);
            chk("status read", pack(pm[i], status), q);
            lhb_host_model_inst.rd(1'h1, q);
            chk("ctrl read", pack(pm[i], ctrl_rd), q);
            lhb_host_model_inst.wr(1'h1, 1'h0, ~d);
            chk("deselected write", {10'h000, e}, {10'h000, idx});
        end
        foreach (bad[i]) begin
            mode_pins = bad[i];
            lhb_host_model_inst.wr(1'h0, 1'h0, 18'h3FFFF);
            chk("invalid flag", 18'h00001, {17'h00000, inv});
            chk("invalid write", {10'h000, e}, {10'h000, idx});
        end
        mode_pins = lhb_pkg::IM_P18;
        wr_ready = 1'h0;
        n0 = pops;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            lhb_host_model_inst.wr(1'h0, 1'h1, rnd[17:0]);
        end
        chk("overruns", 18'h00001, 18'(ovr));
        wr_ready = 1'h1;
        lhb_host_model_inst.gap(8);
        chk("drained words", 18'h00003, 18'(pops - n0));
        chk("newest kept", rnd[17:0], pop_data);
        mode_pins = lhb_pkg::IM_S3;
        d = rnd[17:0] ^ 18'h000C3;
        lhb_host_model_inst.ser(9, 1'h0, {1'h0, d[7:0]}, sq);
        chk("serial index", {10'h000, d[7:0]}, {10'h000, idx});
        mode_pins = lhb_pkg::IM_S4;
        status = ~d;
        lhb_host_model_inst.ser(8, 1'h1, {1'h0, d[15:8]}, sq);
        chk("serial ctrl", {10'h000, d[15:8]}, pop_data);
        chk("serial out", {10'h000, status[7:0]}, {10'h000, sq});
        rgb_mode = 1'h1;
        for (int k = 0; k < 6; k++) begin
            rgb_width = 2'(k % 3);
            edge_pol = 1'(k / 3);
            dv_pol = 1'(k % 2);
            // Park the valid strobe at the new invalid level before counting
            lhb_host_model_inst.pix(edge_pol, ~dv_pol, ~dv_pol, d);
            repeat (3) @(negedge pclk);
            n0 = pixn;
            rnd = lfsr(rnd);
            d = rnd[17:0];
            lhb_host_model_inst.pix(edge_pol, dv_pol, ~dv_pol, d);
            lhb_host_model_inst.pix(edge_pol, ~dv_pol, ~dv_pol, ~d);
            lhb_host_model_inst.gap(8);
            chk("pixel count", 18'(n0 + 1), 18'(pixn));
            chk("pixel data", pixw(rgb_width, d), pix_data);
        end
        report_and_stop();
    end
endmodule
